//--- design/uvep_cfg.svh
`ifndef UVEP_CFG_SVH
`define UVEP_CFG_SVH
// clock period of i_ref_clk
`define UVEP_CLK_PS 50000
// pin timing figures, in picoseconds
`define UVEP_SETUP_PS 2000000
`define UVEP_HOLD_PS 2000000
`define UVEP_VPP_RECOVERY_PS 2000000
`define UVEP_VERIFY_DATA_VALID_PS 1000000
`define UVEP_ADDRESS_ACCESS_PS 550000
`define UVEP_OUTPUT_ENABLE_PS 150000
// programming pulse figures, in microseconds
`define UVEP_PW_STD_NOM_US 50000
`define UVEP_PW_STD_MAX_US 55000
`define UVEP_PW_FAST_NOM_US 10000
`define UVEP_PW_FAST_MAX_US 11000
// extra cycles lost in the data pin synchroniser
`define UVEP_SYNC_CYC 2
// widths
`define UVEP_ADDR_W 12
`define UVEP_DATA_W 8
`define UVEP_TMR_W 21
`endif

//--- design/uvep_pkg.sv
`include "uvep_cfg.svh"
package uvep_pkg;
  typedef enum logic [3:0] {
    UVEP_IDLE = 4'h0,
    UVEP_RD_CE = 4'h1,
    UVEP_RD_OE = 4'h2,
    UVEP_PG_SET = 4'h3,
    UVEP_PG_PULSE = 4'h4,
    UVEP_PG_HOLD = 4'h5,
    UVEP_PG_REC = 4'h6,
    UVEP_VF_WAIT = 4'h7
  } uvep_state_type;
  typedef logic [`UVEP_TMR_W-1:0] uvep_count_type;
  typedef logic [`UVEP_ADDR_W-1:0] uvep_addr_type;
  typedef logic [`UVEP_DATA_W-1:0] uvep_data_type;
endpackage

//--- design/uvep_prog_ctrl.sv
`timescale 1ns/100ps
`include "uvep_cfg.svh"
// Function
// - when programming, the controller drives the whole byte and the address onto the pins.
// - with address and data stable, one low chip enable pulse of 50 ms or 10 ms writes the byte.
// - the programming pulse never exceeds 55 ms, or 11 ms on the fast variant.
// - each location written gets its own pulse, in any order.
// - chip enable is never held low steadily while programming; each pulse returns high.
// - verify reads with both controls low and samples only after the data valid delay.
// - memories taking the same data may share every line and one pulse writes all.
// - on a read, chip enable selects the device and output enable goes low after it, once the sequencer's ACC_OE_CYC timer runs out; verify lowers both at once.
module uvep_prog_ctrl #(
  parameter int PW_STD_CYC = `UVEP_PW_STD_NOM_US * 1000 / (`UVEP_CLK_PS / 1000), // standard pulse
  parameter int PW_STD_MAX_CYC = `UVEP_PW_STD_MAX_US * 1000 / (`UVEP_CLK_PS / 1000), // standard ceiling
  parameter int PW_FAST_CYC = `UVEP_PW_FAST_NOM_US * 1000 / (`UVEP_CLK_PS / 1000), // fast pulse
  parameter int PW_FAST_MAX_CYC = `UVEP_PW_FAST_MAX_US * 1000 / (`UVEP_CLK_PS / 1000) // fast ceiling
) (
  input wire logic i_ref_clk, // 20 MHz clock
  input wire logic i_nrst, // async reset, active low
  input wire logic i_rd_req, // read one byte
  input wire logic i_pg_req, // program and verify one byte
  input wire logic i_fast, // fast-programming variant
  input wire uvep_pkg::uvep_addr_type i_addr, // request address
  input wire uvep_pkg::uvep_data_type i_wdata, // byte to program
  output logic o_busy, // request in progress
  output logic o_done, // one-cycle completion
  output uvep_pkg::uvep_data_type o_rdata, // read or verify byte
  output logic o_fail, // last verify mismatched
  output uvep_pkg::uvep_addr_type o_pin_addr, // address lines
  output logic o_pin_ce_n, // chip enable, active low
  output logic o_pin_oe_n, // output enable logic level, active low
  output logic o_pin_vpp_en, // raise shared pin to programming level
  input wire uvep_pkg::uvep_data_type i_pin_data, // data lines in
  output uvep_pkg::uvep_data_type o_pin_data, // data lines out
  output logic o_pin_data_oe // data lines driven
);
  import uvep_pkg::*;

  // cycle counts derived from the times, rounded up
  function automatic uvep_count_type cyc_up(input int ps);
    cyc_up = uvep_count_type'((ps + `UVEP_CLK_PS - 1) / `UVEP_CLK_PS);
  endfunction
  // pulse width kept at or below its ceiling
  function automatic uvep_count_type cap(input int nom, input int lim);
    cap = uvep_count_type'((nom > lim) ? lim : nom);
  endfunction

  localparam uvep_count_type SETUP_CYC = cyc_up(`UVEP_SETUP_PS);
  localparam uvep_count_type HOLD_CYC = cyc_up(`UVEP_HOLD_PS);
  localparam uvep_count_type VR_CYC = cyc_up(`UVEP_VPP_RECOVERY_PS);
  localparam uvep_count_type DV_CYC = cyc_up(`UVEP_VERIFY_DATA_VALID_PS) + uvep_count_type'(`UVEP_SYNC_CYC);
  localparam uvep_count_type ACC_OE_CYC = cyc_up(`UVEP_ADDRESS_ACCESS_PS - `UVEP_OUTPUT_ENABLE_PS);
  localparam uvep_count_type OE_CYC = cyc_up(`UVEP_OUTPUT_ENABLE_PS) + uvep_count_type'(`UVEP_SYNC_CYC);

  uvep_tmr_if tmr_if ();

  uvep_timer u_timer (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .tmr(tmr_if.tmr)
  );

  // two-flop synchroniser on the data pins
  uvep_data_type din_meta_r;
  uvep_data_type din_sync_r;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      din_meta_r <= '0;
      din_sync_r <= '0;
    end else begin
      din_meta_r <= i_pin_data;
      din_sync_r <= din_meta_r;
    end
  end

  uvep_state_type state_r, state_nxt;
  uvep_addr_type addr_r, addr_nxt;
  uvep_data_type wdata_r, wdata_nxt;
  uvep_data_type rdata_r, rdata_nxt;
  logic ce_n_r, ce_n_nxt;
  logic oe_n_r, oe_n_nxt;
  logic vpp_r, vpp_nxt;
  logic dq_oe_r, dq_oe_nxt;
  logic done_r, done_nxt;
  logic fail_r, fail_nxt;
  logic fast_r, fast_nxt;

  // sequencer: next state, pin levels and timer loads
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    ce_n_nxt = ce_n_r;
    oe_n_nxt = oe_n_r;
    vpp_nxt = vpp_r;
    dq_oe_nxt = dq_oe_r;
    done_nxt = 1'b0;
    fail_nxt = fail_r;
    fast_nxt = fast_r;
    tmr_if.load = 1'b0;
    tmr_if.count = '0;
    case (state_r)
      UVEP_IDLE: begin
        if (i_pg_req) begin
          // raise the pin, present address and byte, then settle
          addr_nxt = i_addr;
          wdata_nxt = i_wdata;
          fast_nxt = i_fast;
          oe_n_nxt = 1'b1;
          vpp_nxt = 1'b1;
          dq_oe_nxt = 1'b1;
          tmr_if.load = 1'b1;
          tmr_if.count = SETUP_CYC;
          state_nxt = UVEP_PG_SET;
        end else if (i_rd_req) begin
          // select first, output enable follows later
          addr_nxt = i_addr;
          ce_n_nxt = 1'b0;
          tmr_if.load = 1'b1;
          tmr_if.count = ACC_OE_CYC;
          state_nxt = UVEP_RD_CE;
        end
      end
      UVEP_RD_CE: begin
        if (tmr_if.expired) begin
          oe_n_nxt = 1'b0;
          tmr_if.load = 1'b1;
          tmr_if.count = OE_CYC;
          state_nxt = UVEP_RD_OE;
        end
      end
      UVEP_RD_OE: begin
        if (tmr_if.expired) begin
          rdata_nxt = din_sync_r;
          ce_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          done_nxt = 1'b1;
          state_nxt = UVEP_IDLE;
        end
      end
      UVEP_PG_SET: begin
        if (tmr_if.expired) begin
          ce_n_nxt = 1'b0;
          tmr_if.load = 1'b1;
          tmr_if.count = fast_r ? cap(PW_FAST_CYC, PW_FAST_MAX_CYC) : cap(PW_STD_CYC, PW_STD_MAX_CYC);
          state_nxt = UVEP_PG_PULSE;
        end
      end
      UVEP_PG_PULSE: begin
        if (tmr_if.expired) begin
          ce_n_nxt = 1'b1;
          tmr_if.load = 1'b1;
          tmr_if.count = HOLD_CYC;
          state_nxt = UVEP_PG_HOLD;
        end
      end
      UVEP_PG_HOLD: begin
        if (tmr_if.expired) begin
          // pin back to logic level, bus released
          vpp_nxt = 1'b0;
          dq_oe_nxt = 1'b0;
          oe_n_nxt = 1'b1;
          tmr_if.load = 1'b1;
          tmr_if.count = VR_CYC;
          state_nxt = UVEP_PG_REC;
        end
      end
      UVEP_PG_REC: begin
        if (tmr_if.expired) begin
          ce_n_nxt = 1'b0;
          oe_n_nxt = 1'b0;
          tmr_if.load = 1'b1;
          tmr_if.count = DV_CYC;
          state_nxt = UVEP_VF_WAIT;
        end
      end
      UVEP_VF_WAIT: begin
        if (tmr_if.expired) begin
          // read-back compare; a 1 written over a cleared cell shows here
          rdata_nxt = din_sync_r;
          fail_nxt = (din_sync_r != wdata_r);
          ce_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          done_nxt = 1'b1;
          state_nxt = UVEP_IDLE;
        end
      end
      default: begin
        ce_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        vpp_nxt = 1'b0;
        dq_oe_nxt = 1'b0;
        state_nxt = UVEP_IDLE;
      end
    endcase
  end

  // sequencer registers; idle pins deselect the memory
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= UVEP_IDLE;
      addr_r <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      vpp_r <= 1'b0;
      dq_oe_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      fast_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      vpp_r <= vpp_nxt;
      dq_oe_r <= dq_oe_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      fast_r <= fast_nxt;
    end
  end

  // pin and user outputs
  assign o_busy = (state_r != UVEP_IDLE);
  assign o_done = done_r;
  assign o_rdata = rdata_r;
  assign o_fail = fail_r;
  assign o_pin_addr = addr_r;
  assign o_pin_ce_n = ce_n_r;
  assign o_pin_oe_n = oe_n_r;
  assign o_pin_vpp_en = vpp_r;
  assign o_pin_data = wdata_r;
  assign o_pin_data_oe = dq_oe_r;
endmodule

//--- design/uvep_timer.sv
`timescale 1ns/100ps
module uvep_timer (
  input wire logic i_ref_clk, // reference clock
  input wire logic i_nrst, // async reset, active low
  uvep_tmr_if.tmr tmr // load and expiry
);
  import uvep_pkg::*;
  uvep_count_type cnt_r;
  uvep_count_type cnt_nxt;

  // down counter, reload wins over counting
  always_comb begin
    cnt_nxt = cnt_r;
    if (tmr.load) begin
      cnt_nxt = tmr.count;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - uvep_count_type'(1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // level while the wait has run out
  assign tmr.expired = (cnt_r == '0);
endmodule

//--- design/uvep_tmr_if.sv
`timescale 1ns/100ps
interface uvep_tmr_if;
  import uvep_pkg::*;
  logic load;
  uvep_count_type count;
  logic expired;
  modport ctl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface

//--- verification/uvep_mem_model.sv
`timescale 1ns/100ps
// memory at the far side of the pins
module uvep_mem_model (
  input wire uvep_pkg::uvep_addr_type i_addr, // address
  input wire logic i_ce_n, // chip enable
  input wire logic i_oe_n, // output enable
  input wire logic i_vpp_en, // programming level
  input wire uvep_pkg::uvep_data_type i_data, // data in
  output uvep_pkg::uvep_data_type o_data, // data out
  output logic o_drive // outputs on
);
  import uvep_pkg::*;
  uvep_data_type mem [4096];
  // erased array
  initial begin
    foreach (mem[k]) begin
      mem[k] = 8'hFF;
    end
  end
  // output gate, garbage when floating
  assign o_drive = !i_ce_n && !i_oe_n && !i_vpp_en;
  assign #100 o_data = o_drive ? mem[i_addr] : ~mem[i_addr];
  // pulse end clears zero bits
  always @(posedge i_ce_n) begin
    if (i_vpp_en) begin
      mem[i_addr] = mem[i_addr] & i_data;
    end
  end
endmodule

//--- verification/uvep_prog_ctrl_assertions.sv
`timescale 1ns/100ps
// pin protocol checks
module uvep_prog_ctrl_assertions #(
  parameter int PW_STD_CYC = 20, // std pulse
  parameter int PW_STD_MAX_CYC = 25, // std ceiling
  parameter int PW_FAST_CYC = 10, // fast pulse
  parameter int PW_FAST_MAX_CYC = 15 // fast ceiling
) (
  input wire logic i_ref_clk, // clock
  input wire logic i_nrst, // reset
  input wire logic i_rd_req, // read
  input wire logic i_pg_req, // program
  input wire logic i_fast, // fast
  input wire uvep_pkg::uvep_addr_type i_addr, // addr
  input wire uvep_pkg::uvep_data_type i_wdata, // byte
  input wire logic o_busy, // busy
  input wire logic o_done, // done
  input wire uvep_pkg::uvep_data_type o_rdata, // rdata
  input wire logic o_fail, // fail
  input wire uvep_pkg::uvep_addr_type o_pin_addr, // pins
  input wire logic o_pin_ce_n, // ce
  input wire logic o_pin_oe_n, // oe
  input wire logic o_pin_vpp_en, // vpp
  input wire uvep_pkg::uvep_data_type i_pin_data, // in
  input wire uvep_pkg::uvep_data_type o_pin_data, // out
  input wire logic o_pin_data_oe // drive
);
  import uvep_pkg::*;
  int pw_cnt_r;
  int pw_cnt_nxt;
  logic fast_seen_r;
  logic fast_seen_nxt;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // pulse length counter
  always_comb begin
    pw_cnt_nxt = (!o_pin_ce_n && o_pin_vpp_en) ? pw_cnt_r + 1 : 0;
    fast_seen_nxt = (i_pg_req && !o_busy) ? i_fast : fast_seen_r; // variant of the running program
  end
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pw_cnt_r <= 0;
      fast_seen_r <= 1'b0;
    end else begin
      pw_cnt_r <= pw_cnt_nxt;
      fast_seen_r <= fast_seen_nxt;
    end
  end
  // read steps
  sequence s_rd_sel;
    (!o_pin_ce_n && o_pin_oe_n)[*8] ##1 (!o_pin_ce_n && o_pin_oe_n);
  endsequence
  sequence s_rd_gate;
    (!o_pin_ce_n && !o_pin_oe_n && !o_pin_vpp_en)[*6];
  endsequence
  AST_READ_WALK: assert property ((i_rd_req && !i_pg_req && !o_busy) |=> s_rd_sel ##1 s_rd_gate ##1 o_done)
    else $error("read sequence wrong");
  AST_DRIVE_PROG: assert property (o_pin_data_oe |-> o_pin_vpp_en && o_pin_oe_n)
    else $error("data driven outside programming");
  AST_SETUP: assert property ($rose(o_pin_vpp_en) |-> o_pin_ce_n[*8] ##34 !o_pin_ce_n)
    else $error("pulse setup wrong");
  AST_PULSE_WIDTH: assert property ($rose(o_pin_ce_n) && o_pin_vpp_en
    |-> pw_cnt_r == (fast_seen_r ? PW_FAST_CYC : PW_STD_CYC) + 1)
    else $error("pulse width wrong");
  AST_PULSE_MAX: assert property (!o_pin_ce_n && o_pin_vpp_en
    |-> pw_cnt_r < (fast_seen_r ? PW_FAST_MAX_CYC : PW_STD_MAX_CYC))
    else $error("pulse too long");
  AST_RECOVERY: assert property ($fell(o_pin_vpp_en) |-> (o_pin_ce_n && !o_pin_data_oe)[*8])
    else $error("no recovery before verify");
  AST_VERIFY: assert property ($fell(o_pin_ce_n) && $fell(o_pin_oe_n) |-> !o_done[*8] ##[13:16] o_done)
    else $error("verify sample time wrong");
  AST_DONE_IDLE: assert property (o_done |-> !o_busy && o_pin_ce_n && o_pin_oe_n && !o_pin_vpp_en)
    else $error("device not idle at done");
  AST_DONE_ONE: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
endmodule

//--- verification/uvep_prog_ctrl_tb_top.sv
`timescale 1ns/100ps
// bench for the controller
module uvep_prog_ctrl_tb_top;
  import uvep_pkg::*;
  typedef struct packed {uvep_data_type data; logic fail;} uvep_note_type;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_rd_req = 1'b0;
  logic i_pg_req = 1'b0;
  logic i_fast = 1'b0;
  uvep_addr_type i_addr = 12'h000;
  uvep_data_type i_wdata = 8'h00;
  logic o_busy, o_done, o_fail, o_pin_ce_n, o_pin_oe_n, o_pin_vpp_en, o_pin_data_oe, mem_drive;
  uvep_data_type o_rdata, o_pin_data, mem_data, pin_data;
  uvep_addr_type o_pin_addr;
  uvep_data_type ref_mem [4096];
  uvep_note_type notes [$];
  uvep_note_type note;
  logic last_fail = 1'b0;
  int n_mismatch = 0;
  int n_compared = 0;
  always #25 i_ref_clk = ~i_ref_clk;
  // data wire
  assign pin_data = o_pin_data_oe ? o_pin_data : mem_data;
  uvep_prog_ctrl #(.PW_STD_CYC(20), .PW_STD_MAX_CYC(25), .PW_FAST_CYC(10), .PW_FAST_MAX_CYC(15)) dut (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_rd_req(i_rd_req), .i_pg_req(i_pg_req), .i_fast(i_fast),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata), .o_fail(o_fail),
    .o_pin_addr(o_pin_addr), .o_pin_ce_n(o_pin_ce_n), .o_pin_oe_n(o_pin_oe_n), .o_pin_vpp_en(o_pin_vpp_en),
    .i_pin_data(pin_data), .o_pin_data(o_pin_data), .o_pin_data_oe(o_pin_data_oe));
  uvep_mem_model u_mem (.i_addr(o_pin_addr), .i_ce_n(o_pin_ce_n), .i_oe_n(o_pin_oe_n),
    .i_vpp_en(o_pin_vpp_en), .i_data(pin_data), .o_data(mem_data), .o_drive(mem_drive));
  // twin memory on every shared line, outputs left open
  uvep_mem_model u_mem2 (.i_addr(o_pin_addr), .i_ce_n(o_pin_ce_n), .i_oe_n(o_pin_oe_n),
    .i_vpp_en(o_pin_vpp_en), .i_data(pin_data), .o_data(), .o_drive());
  task automatic chk8(input string what, input uvep_data_type exp, input uvep_data_type got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask
  // one request, note the result, wait for idle
  task automatic op(input logic pg, input logic rd, input logic f, input uvep_addr_type a, input uvep_data_type d);
    int n = 0;
    uvep_note_type e;
    e.data = ref_mem[a];
    e.fail = last_fail;
    if (pg) begin
      e.data = ref_mem[a] & d;
      e.fail = (e.data != d);
      ref_mem[a] = e.data;
    end
    last_fail = e.fail;
    notes.push_back(e);
    i_pg_req = pg;
    i_rd_req = rd;
    i_fast = f;
    i_addr = a;
    i_wdata = d;
    @(posedge i_ref_clk);
    #2;
    i_pg_req = 1'b0;
    i_rd_req = 1'b0;
    i_addr = ~a;
    i_wdata = ~d;
    while (o_busy === 1'b1 && n < 3000) begin
      @(posedge i_ref_clk);
      #2;
      n++;
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // compare each completion with the oldest note
  always @(negedge i_ref_clk) begin
    if (o_pin_data_oe === 1'b1) begin
      chk1("bus_contention", 1'b0, mem_drive);
    end
    if (o_done === 1'b1) begin
      note = notes.pop_front();
      chk8("o_rdata", note.data, o_rdata);
      chk1("o_fail", note.fail, o_fail);
    end
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_mismatch++;
    end_sim();
  end
  // main sequence
  initial begin
    foreach (ref_mem[k]) begin
      ref_mem[k] = 8'hFF;
    end
    void'($urandom(27380));
    repeat (6) @(posedge i_ref_clk);
    #2;
    i_nrst = 1'b1;
    op(0, 1, 0, 12'h000, 8'h00);
    op(1, 0, 1, 12'hFFF, 8'hA5);
    op(0, 1, 0, 12'hFFF, 8'h00);
    op(1, 0, 0, 12'hFFF, 8'hFF);
    op(1, 1, 1, 12'h001, 8'h3C);
    op(0, 1, 0, 12'h001, 8'h00);
    repeat (12) begin
      op(1'($urandom), 1'b1, 1'($urandom), uvep_addr_type'($urandom_range(0, 7)), 8'($urandom));
    end
    repeat (2) @(posedge i_ref_clk);
    chk1("notes_empty", 1'b1, notes.size() == 0);
    for (int k = 0; k < 8; k++) begin
      chk8("twin_mem", ref_mem[k], u_mem2.mem[k]);
    end
    chk8("twin_mem", ref_mem[12'hFFF], u_mem2.mem[12'hFFF]);
    end_sim();
  end
endmodule
bind uvep_prog_ctrl uvep_prog_ctrl_assertions #(.PW_STD_CYC(PW_STD_CYC), .PW_STD_MAX_CYC(PW_STD_MAX_CYC),
  .PW_FAST_CYC(PW_FAST_CYC), .PW_FAST_MAX_CYC(PW_FAST_MAX_CYC)) u_chk (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_rd_req(i_rd_req), .i_pg_req(i_pg_req), .i_fast(i_fast),
  .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata), .o_fail(o_fail),
  .o_pin_addr(o_pin_addr), .o_pin_ce_n(o_pin_ce_n), .o_pin_oe_n(o_pin_oe_n), .o_pin_vpp_en(o_pin_vpp_en),
  .i_pin_data(i_pin_data), .o_pin_data(o_pin_data), .o_pin_data_oe(o_pin_data_oe));
